// ==== dsau_access_unit.sv ====
// Data space decode, byte lane steering, alignment trap and program segmentation
// Functional notes
// [RULE1] Data addresses are byte addresses; 0000h-7FFFh map to on-chip memory.
// [RULE2] Addresses 8000h-FFFFh go through the extended data region window.
// [RULE3] Low byte sits at the even address, high byte at the odd address.
// [RULE4] Post-increment pointer step is one for bytes, two for words.
// [RULE5] Byte reads fetch the word; address bit zero picks the byte onto low lane.
// [RULE6] Byte writes strobe only the matching lane; one shared word decode.
// [RULE7] Word access at an odd address raises an address error trap.
// [RULE8] Misaligned read completes; misaligned write is suppressed; trap follows.
// [RULE9] Byte load into a working register changes only its low byte.
// [RULE10] Near region 0000h-1FFFh reachable by 13-bit direct address field.
// [RULE11] Move instructions use a 16-bit direct address reaching all data space.
// [RULE12] 0000h-07FFh decodes as the special-function register region.
// [RULE13] Unimplemented special-function addresses read back as zero.
// [RULE14] 256-byte one-time area at 801700h-8017FEh, never erased by chip erase.
// [RULE15] Programmer writes each one-time location at most once.
// [RULE16] 13-bit limit splits user space into boot and general segments.
// [RULE17] Configuration data is loaded from user flash during reset.
// [RULE18] Separate read and write address generators access the data space.
// [RULE19] Alternate vector table sits at (limit minus one) times 0x800.
// [RULE20] Address error is a one-cycle trap pulse with read/write indication.
// [RULE21] Bit zero is the alignment check, ignored in aligned word addresses.
`include "dsau_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module dsau_access_unit
  import dsau_pkg::*;
(
  // Clock and reset
  input  wire logic         sys_clk_in,
  input  wire logic         rst_b_in,
  // Configuration load from flash during reset sequence
  input  wire logic         cfg_valid_in,
  input  wire logic [12:0]  cfg_bs_limit_in,
  input  wire logic         cfg_alt_vt_en_in,
  output logic              cfg_done_out,
  // Read address generator
  input  wire dsau_rreq_t   rd_req_in,
  output logic [15:0]       rd_data_out,
  output logic              rd_valid_out,
  output dsau_region_t      rd_region_out,
  // Write address generator
  input  wire dsau_wreq_t   wr_req_in,
  output dsau_region_t      wr_region_out,
  // Direct address forms from the decoder
  input  wire logic         dir_near_in,
  input  wire logic [15:0]  dir_field_in,
  output logic [15:0]       dir_addr_out,
  output logic              dir_is_near_out,
  // Pointer post-increment
  input  wire logic [15:0]  ptr_in,
  input  wire logic         ptr_byte_in,
  output logic [15:0]       ptr_next_out,
  // Working register byte load
  input  wire logic [15:0]  wreg_old_in,
  input  wire logic [7:0]   wreg_byte_in,
  output logic [15:0]       wreg_merged_out,
  // Memory array, one word read port and one word write port
  output logic [14:0]       mem_rd_addr_out,
  input  wire logic [15:0]  mem_rd_data_in,
  input  wire logic         sfr_hit_in,
  output logic [14:0]       mem_wr_addr_out,
  output logic [1:0]        mem_lane_we_out,
  output logic [15:0]       mem_wr_data_out,
  // Extended region window
  output logic              ext_rd_out,
  output logic              ext_wr_out,
  input  wire logic [15:0]  ext_rd_data_in,
  // Program space classification
  input  wire logic [23:0]  prog_addr_in,
  output logic              prog_in_boot_out,
  output logic              prog_in_general_out,
  output logic              prog_in_otp_out,
  output logic [23:0]       alt_vt_base_out,
  // Exception logic
  output logic              addr_trap_out,
  output logic              addr_trap_is_wr_out
);

  ////////////////////////////////////////////////////////////////////////////
  dsau_state_all_t s_r;
  dsau_state_all_t s_nxt;

  logic        rd_mis;
  logic        wr_mis;
  logic        rd_ext;
  logic        wr_ext;
  logic [15:0] word_rd;
  logic [23:0] bs_end;
  logic [23:0] gs_start;
  logic [23:0] lim_x;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and pure datapath helpers
  always_comb begin
    rd_mis = rd_req_in.valid && !rd_req_in.is_byte && rd_req_in.addr[0]; // see [RULE7]
    wr_mis = wr_req_in.valid && !wr_req_in.is_byte && wr_req_in.addr[0]; // see [RULE7]
    rd_ext = rd_req_in.addr >= `DSAU_EXT_BASE; // see [RULE2]
    wr_ext = wr_req_in.addr >= `DSAU_EXT_BASE; // see [RULE2]
    if (rd_ext) begin
      rd_region_out = DSAU_REGION_EXT;
    end else if (rd_req_in.addr <= `DSAU_SFR_TOP) begin
      rd_region_out = DSAU_REGION_SFR; // see [RULE12]
    end else begin
      rd_region_out = DSAU_REGION_RAM; // see [RULE1]
    end
    if (wr_ext) begin
      wr_region_out = DSAU_REGION_EXT;
    end else if (wr_req_in.addr <= `DSAU_SFR_TOP) begin
      wr_region_out = DSAU_REGION_SFR;
    end else begin
      wr_region_out = DSAU_REGION_RAM;
    end
    // Word address drops bit zero for both generators
    mem_rd_addr_out = rd_req_in.addr[15:1]; // see [RULE18] see [RULE21]
    ext_rd_out      = rd_req_in.valid && rd_ext;
    ext_wr_out      = wr_req_in.valid && wr_ext && !wr_mis;
    // Near form zero-extends the 13-bit field; move form uses all 16 bits
    dir_addr_out    = dir_near_in ? {3'b000, dir_field_in[12:0]} : dir_field_in; // see [RULE10] see [RULE11]
    dir_is_near_out = dir_addr_out <= `DSAU_NEAR_TOP; // see [RULE10]
    ptr_next_out    = ptr_in + (ptr_byte_in ? `DSAU_STEP_BYTE : `DSAU_STEP_WORD); // see [RULE4]
    wreg_merged_out = {wreg_old_in[15:8], wreg_byte_in}; // see [RULE9]
    // Segmentation: boot segment runs from end of vector area to the page below the limit page
    lim_x    = {11'h000, s_r.bs_limit} * `DSAU_PAGE_SIZE;
    alt_vt_base_out = {11'h000, s_r.bs_limit - `DSAU_LIM_ONE} * `DSAU_PAGE_SIZE; // see [RULE19]
    bs_end   = lim_x;
    gs_start = (s_r.alt_vt_en && s_r.bs_limit > `DSAU_LIM_ONE) ?
               alt_vt_base_out + `DSAU_PAGE_SIZE : bs_end; // see [RULE16]
    prog_in_boot_out    = prog_addr_in >= `DSAU_IVT_END && prog_addr_in < bs_end &&
                          prog_addr_in < alt_vt_base_out; // see [RULE16]
    prog_in_general_out = prog_addr_in >= gs_start && prog_addr_in >= `DSAU_IVT_END &&
                          !prog_in_otp_out; // see [RULE16]
  end

  // One-time area: decode only, no erase path exists here
  assign prog_in_otp_out = prog_addr_in >= `DSAU_OTP_FIRST &&
                           prog_addr_in <= `DSAU_OTP_LAST; // see [RULE14]

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_nxt          = s_r;
    s_nxt.rd_done  = 1'b0;
    s_nxt.trap     = 1'b0;
    s_nxt.mwr.lane_we = 2'b00;
    word_rd        = s_r.rd_ext ? ext_rd_data_in : mem_rd_data_in;
    case (s_r.state)
      DSAU_ST_IDLE: begin
        s_nxt.state = DSAU_ST_CFG;
      end
      DSAU_ST_CFG: begin
        // Hold array accesses and traps off until flash configuration arrives; ext_rd_out and ext_wr_out are not held
        if (cfg_valid_in) begin
          s_nxt.bs_limit  = cfg_bs_limit_in; // see [RULE17]
          s_nxt.alt_vt_en = cfg_alt_vt_en_in;
          s_nxt.state     = DSAU_ST_READY;
        end
      end
      DSAU_ST_READY: begin
        // Read data returns two cycles after the address
        if (s_r.rd_pend) begin
          s_nxt.rd_done = 1'b1;
          if (s_r.rd_sfr && !sfr_hit_in) begin
            s_nxt.rd_data = `DSAU_ZERO16; // see [RULE13]
          end else if (s_r.rd_byte) begin
            s_nxt.rd_data = {`DSAU_ZERO8, s_r.rd_odd ? word_rd[15:8] : word_rd[7:0]}; // see [RULE5] see [RULE3]
          end else begin
            s_nxt.rd_data = word_rd;
          end
        end
        // Misaligned read still completes; trap comes one cycle before its data
        s_nxt.rd_pend = rd_req_in.valid;
        s_nxt.rd_odd  = rd_req_in.addr[0];
        s_nxt.rd_byte = rd_req_in.is_byte;
        s_nxt.rd_ext  = rd_ext;
        s_nxt.rd_sfr  = rd_req_in.addr <= `DSAU_SFR_TOP;
        if (wr_req_in.valid && !wr_mis) begin
          s_nxt.mwr.word_addr = wr_req_in.addr[15:1]; // see [RULE21]
          if (wr_req_in.is_byte) begin
            s_nxt.mwr.lane_we = wr_req_in.addr[0] ? 2'b10 : 2'b01; // see [RULE6] see [RULE3]
            s_nxt.mwr.wdata   = {wr_req_in.wdata[7:0], wr_req_in.wdata[7:0]};
          end else begin
            s_nxt.mwr.lane_we = 2'b11;
            s_nxt.mwr.wdata   = wr_req_in.wdata;
          end
          if (wr_ext) begin
            s_nxt.mwr.lane_we = 2'b00;
          end
        end
        // Write fault wins the indication when both fault together
        if (rd_mis || wr_mis) begin
          s_nxt.trap       = 1'b1; // see [RULE8] see [RULE20]
          s_nxt.trap_is_wr = wr_mis;
        end
      end
      default: begin
        s_nxt.state = DSAU_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign cfg_done_out        = s_r.state == DSAU_ST_READY;
  assign rd_data_out         = s_r.rd_data;
  assign rd_valid_out        = s_r.rd_done;
  assign mem_wr_addr_out     = s_r.mwr.word_addr;
  assign mem_lane_we_out     = s_r.mwr.lane_we;
  assign mem_wr_data_out     = s_r.mwr.wdata;
  assign addr_trap_out       = s_r.trap;
  assign addr_trap_is_wr_out = s_r.trap_is_wr;

endmodule

`default_nettype wire

// ==== dsau_access_unit_test.sv ====
// Self-checking random bench for the data space access unit
`timescale 1ns/1ps
`default_nettype none
module dsau_access_unit_test
  import dsau_pkg::*;
;
  logic sys_clk_in = 1'b0, rst_b_in = 1'b0, cfg_valid_in = 1'b0, cfg_alt_vt_en_in, cfg_done_out;
  logic [12:0] cfg_bs_limit_in;
  dsau_rreq_t rd_req_in, r1 = '0, r2 = '0;
  dsau_wreq_t wr_req_in, w1;
  dsau_region_t rd_region_out, wr_region_out;
  logic [15:0] rd_data_out, dir_field_in, dir_addr_out, ptr_in, ptr_next_out, wreg_old_in;
  logic [15:0] wreg_merged_out, mem_rd_data_in, mem_wr_data_out, ext_rd_data_in, e, ed;
  logic [14:0] mem_rd_addr_out, mem_wr_addr_out;
  logic [23:0] prog_addr_in, alt_vt_base_out;
  logic [7:0] wreg_byte_in;
  logic [1:0] mem_lane_we_out, lw;
  logic rd_valid_out, dir_near_in, dir_is_near_out, ptr_byte_in, sfr_hit_in, ext_rd_out;
  logic ext_wr_out, prog_in_boot_out, prog_in_general_out, prog_in_otp_out, addr_trap_out;
  logic addr_trap_is_wr_out, wm, rm;
  logic [31:0] rnd;
  int errors = 0, n_tests = 0, cyc = 0, k;
  integer seed = 32'h0116_87bb;
  logic [23:0] pa [6] = '{24'h80_1700, 24'h80_17FE, 24'h80_16FE, 24'h80_1800, 24'h00_0400,
                          24'h00_3000};
  logic [2:0] pe [6] = '{3'b100, 3'b100, 3'b000, 3'b000, 3'b010, 3'b001};
  dsau_access_unit DUT (.*);
  dsau_mem_model u_mem (.clk_in(sys_clk_in), .rd_addr_in(mem_rd_addr_out), .ext_rd_in(ext_rd_out),
    .rd_data_out(mem_rd_data_in), .ext_data_out(ext_rd_data_in), .sfr_hit_out(sfr_hit_in));
  always #4 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      print_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, ex, got);
    end
  endtask
  task automatic print_verdict;
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Model contents: unimplemented special registers read as zero
  function automatic logic [15:0] mem_word(input logic [15:0] a);
    logic [15:0] d;
    d = {a[15:1], 1'b0} ^ 16'h5A3C;
    if (a[15]) d = ~d;
    else if (a <= 16'h07FF && !a[5]) d = 16'h0000;
    return d;
  endfunction
  // Random address, biased toward region edges
  function automatic logic [15:0] pick(input logic [31:0] r);
    logic [15:0] a;
    a = r[15:0];
    case (r[19:17])
      3'd0: a[15:11] = 5'h00;
      3'd1: a[15] = 1'b0;
      3'd2: a = (r[16] ? 16'h0800 : 16'h8000) - {15'h0000, r[20]};
      default: ;
    endcase
    return a;
  endfunction
  //////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    rd_req_in = '0;
    wr_req_in = '0;
    {cfg_bs_limit_in, cfg_alt_vt_en_in, dir_near_in, dir_field_in} = {13'h0004, 2'b11, 16'hABCD};
    {ptr_in, ptr_byte_in, wreg_old_in, wreg_byte_in, prog_addr_in} = '0;
    repeat (20) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    cfg_valid_in <= 1'b1;
    for (k = 0; k < 20 && cfg_done_out !== 1'b1; k++) @(posedge sys_clk_in);
    chk("cfg_done", 32'h0000_0001, {31'h0, cfg_done_out});
    chk("alt_vt_base", 32'h0000_1800, {8'h00, alt_vt_base_out});
    // Decode only: the one-time area is never written, let alone twice
    for (k = 0; k < 6; k++) begin
      @(posedge sys_clk_in);
      prog_addr_in <= pa[k];
      dir_near_in <= k[0];
      #1;
      chk("otp", {31'h0, pe[k][2]}, {31'h0, prog_in_otp_out});
      if (!pa[k][23])
        chk("segment", {30'h0, pe[k][1:0]}, {30'h0, prog_in_boot_out, prog_in_general_out});
      chk("direct", k[0] ? 32'h0001_0BCD : 32'h0000_ABCD,
          {15'h0, dir_is_near_out, dir_addr_out});
    end
    for (k = 0; k < 600; k++) begin
      @(posedge sys_clk_in);
      r2 = r1;
      r1 = rd_req_in;
      w1 = wr_req_in;
      rnd = $random(seed);
      rd_req_in <= '{valid: rnd[0] | rnd[1], is_byte: rnd[2], addr: pick($random(seed))};
      wr_req_in <= '{rnd[3] | rnd[4], rnd[5], pick($random(seed)), rnd[31:16]};
      {ptr_in, ptr_byte_in} <= {rnd[15:8], rnd[31:24], rnd[6]};
      {wreg_old_in, wreg_byte_in} <= rnd[31:8];
      #1;
      chk("wreg", {16'h0, wreg_old_in[15:8], wreg_byte_in}, {16'h0, wreg_merged_out});
      // Write region and read window strobe follow the freshly driven request
      lw = wr_req_in.addr[15] ? 2'b10 : wr_req_in.addr <= 16'h07FF ? 2'b00 : 2'b01;
      chk("wr_region", {30'h0, lw}, {30'h0, wr_region_out});
      chk("ext_rd", {31'h0, rd_req_in.valid & rd_req_in.addr[15]}, {31'h0, ext_rd_out});
      wm = w1.valid && !w1.is_byte && w1.addr[0];
      rm = r1.valid && !r1.is_byte && r1.addr[0];
      chk("trap", {30'h0, rm | wm, wm},
          {30'h0, addr_trap_out, addr_trap_is_wr_out & addr_trap_out});
      lw = !w1.valid || wm || w1.addr[15] ? 2'b00 : !w1.is_byte ? 2'b11 : w1.addr[0] ? 2'b10 : 2'b01;
      chk("lane_we", {30'h0, lw}, {30'h0, mem_lane_we_out});
      ed = w1.is_byte ? {2{w1.wdata[7:0]}} : w1.wdata;
      if (lw != 2'b00)
        chk("wr_addr_data", {1'b0, w1.addr[15:1], ed},
            {1'b0, mem_wr_addr_out, mem_wr_data_out});
      chk("rd_valid", {31'h0, r2.valid}, {31'h0, rd_valid_out});
      e = mem_word(r2.addr);
      ed = !r2.is_byte ? e : {8'h00, r2.addr[0] ? e[15:8] : e[7:0]};
      if (r2.valid)
        chk("rd_data", {16'h0, ed}, {16'h0, rd_data_out});
    end
    print_verdict();
  end
endmodule
`default_nettype wire

// ==== dsau_checker.sv ====
// Port-level assertions for the data space access unit
`timescale 1ns/1ps
`default_nettype none
module dsau_checker
  import dsau_pkg::*;
(
  // Clock and reset
  input wire logic         sys_clk_in,
  input wire logic         rst_b_in,
  // Watched ports
  input wire logic         cfg_done_out,
  input wire dsau_rreq_t   rd_req_in,
  input wire dsau_wreq_t   wr_req_in,
  input wire logic         rd_valid_out,
  input wire dsau_region_t rd_region_out,
  input wire logic         ext_wr_out,
  input wire logic [1:0]   mem_lane_we_out,
  input wire logic [14:0]  mem_wr_addr_out,
  input wire logic [15:0]  ptr_in,
  input wire logic         ptr_byte_in,
  input wire logic [15:0]  ptr_next_out,
  input wire logic         addr_trap_out,
  input wire logic         addr_trap_is_wr_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  logic        rmis, wmis, wok, mis;
  logic [15:0] waddr_q;
  assign rmis = cfg_done_out && rd_req_in.valid && !rd_req_in.is_byte && rd_req_in.addr[0];
  assign wmis = cfg_done_out && wr_req_in.valid && !wr_req_in.is_byte && wr_req_in.addr[0];
  assign wok  = cfg_done_out && wr_req_in.valid && !wmis;
  assign mis  = rmis || wmis;
  // Write address one cycle back, so the lane check needs no nested sampled values
  always_ff @(posedge sys_clk_in) waddr_q <= wr_req_in.addr;
  //////////////////////////////////////////////////////////////////////////////////////////////
  property p_trap_wr; wmis |=> addr_trap_out && addr_trap_is_wr_out; endproperty
  a_trap_wr: assert property (p_trap_wr) else $error("odd word write gave no write trap");
  property p_trap_rd; rmis && !wmis |=> addr_trap_out && !addr_trap_is_wr_out; endproperty
  a_trap_rd: assert property (p_trap_rd) else $error("odd word read gave no read trap");
  property p_trap_cause; addr_trap_out |-> $past(mis); endproperty
  a_trap_cause: assert property (p_trap_cause) else $error("trap without odd word access");
  property p_wr_block; wmis |-> !ext_wr_out ##1 mem_lane_we_out == 2'b00; endproperty
  a_wr_block: assert property (p_wr_block) else $error("odd word write reached memory");
  property p_ext_win; wok && wr_req_in.addr[15] |-> ext_wr_out ##1 mem_lane_we_out == 2'b00;
  endproperty
  a_ext_win: assert property (p_ext_win) else $error("upper half write not sent to window");
  property p_byte_lane; wok && wr_req_in.is_byte && !wr_req_in.addr[15] |=>
    mem_lane_we_out == (waddr_q[0] ? 2'b10 : 2'b01) && mem_wr_addr_out == waddr_q[15:1];
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("byte write lane wrong");
  property p_rd_pulse; cfg_done_out && rd_req_in.valid |-> ##2 rd_valid_out; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read data valid late");
  property p_region; rd_region_out == (rd_req_in.addr[15] ? DSAU_REGION_EXT :
    rd_req_in.addr <= 16'h07FF ? DSAU_REGION_SFR : DSAU_REGION_RAM); endproperty
  a_region: assert property (p_region) else $error("read region decode wrong");
  property p_ptr; ptr_next_out == ptr_in + (ptr_byte_in ? 16'h0001 : 16'h0002); endproperty
  a_ptr: assert property (p_ptr) else $error("pointer step wrong");
  c_wr_trap: cover property (wmis);
  c_rd_done: cover property (rd_valid_out);
  c_odd_byte: cover property (mem_lane_we_out == 2'b10);
endmodule
bind dsau_access_unit dsau_checker u_chk (.*);
`default_nettype wire

// ==== dsau_consts.svh ====
// Constants for the data space access unit
`ifndef DSAU_CONSTS_SVH
`define DSAU_CONSTS_SVH
`define DSAU_EXT_BASE      16'h8000
`define DSAU_NEAR_TOP      16'h1FFF
`define DSAU_SFR_TOP       16'h07FF
`define DSAU_STEP_BYTE     16'h0001
`define DSAU_STEP_WORD     16'h0002
`define DSAU_OTP_FIRST     24'h80_1700
`define DSAU_OTP_LAST      24'h80_17FE
`define DSAU_IVT_END       24'h00_0200
`define DSAU_PAGE_SIZE     24'h00_0800
`define DSAU_ZERO16        16'h0000
`define DSAU_ZERO8         8'h00
`define DSAU_LIM_ONE       13'h0001
`endif

// ==== dsau_mem_model.sv ====
// Memory array and window model answering the unit's reads one cycle later
`timescale 1ns/1ps
`default_nettype none
module dsau_mem_model (
  // Clock
  input  wire logic        clk_in,
  // Requests from the unit
  input  wire logic [14:0] rd_addr_in,
  input  wire logic        ext_rd_in,
  // Answers
  output logic [15:0]      rd_data_out,
  output logic [15:0]      ext_data_out,
  output logic             sfr_hit_out
);
  logic [14:0] addr_q;
  logic        ext_q;
  logic [15:0] pat;
  always_ff @(posedge clk_in) begin
    addr_q <= rd_addr_in;
    ext_q <= ext_rd_in;
  end
  assign pat = {addr_q, 1'b0} ^ 16'h5A3C;
  assign rd_data_out = pat;
  // Window undriven without a strobe: swapped bytes so a stray use shows
  assign ext_data_out = ext_q ? ~pat : {pat[7:0], pat[15:8]};
  assign sfr_hit_out = addr_q[4];
endmodule
`default_nettype wire

// ==== dsau_pkg.sv ====
// Types for the data space access unit
package dsau_pkg;
  typedef enum logic [1:0] {
    DSAU_REGION_SFR = 2'b00,
    DSAU_REGION_RAM = 2'b01,
    DSAU_REGION_EXT = 2'b10
  } dsau_region_t;

  typedef enum logic [1:0] {
    DSAU_ST_IDLE  = 2'b00,
    DSAU_ST_CFG   = 2'b01,
    DSAU_ST_READY = 2'b10
  } dsau_state_t;

  typedef struct packed {
    logic        valid;
    logic        is_byte;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dsau_wreq_t;

  typedef struct packed {
    logic        valid;
    logic        is_byte;
    logic [15:0] addr;
  } dsau_rreq_t;

  typedef struct packed {
    logic [14:0] word_addr;
    logic [1:0]  lane_we;
    logic [15:0] wdata;
  } dsau_mem_wr_t;

  typedef struct packed {
    dsau_state_t state;
    logic [12:0] bs_limit;
    logic        alt_vt_en;
    logic        rd_pend;
    logic        rd_odd;
    logic        rd_sfr;
    logic        rd_byte;
    logic        rd_ext;
    logic [15:0] rd_data;
    logic        rd_done;
    logic        trap;
    logic        trap_is_wr;
    dsau_mem_wr_t mwr;
  } dsau_state_all_t;
endpackage
